// [pic_defs.svh]
// register offsets, field positions, reset values and timing counts of the pi controller
// What this block does
// RQ1 - manual mode drives output with manual value
// RQ2 - auto mode computes output from control law
// RQ3 - auto entry seeds integral sum with manual value
// RQ4 - scaled input is input times gain plus offset
// RQ5 - output held while scaled input equals setpoint
// RQ6 - upward action: above setpoint lowers output
// RQ7 - downward action: above setpoint raises output
// RQ8 - keep stepping; step size from gain, time
// RQ9 - input above max uses max as value
// RQ10 - input below min uses min as value
// RQ11 - reset input resets the output
// RQ12 - reset input disables the mode select
// RQ13 - control calculation runs every 500 ms
// RQ14 - zero proportional gain drops proportional term
// RQ15 - integral time 99:59 drops integral term
// RQ16 - output stays within 0 to 1000; manual mode and auto entry load the manual value without this limit
// RQ17 - reset forces output to zero
// RQ18 - tick from clock counter; output changes only on ticks, on reset input and on auto entry
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_OFS_CTRL      12'h000
`define PIC_OFS_SETPOINT  12'h004
`define PIC_OFS_GAIN_A    12'h008
`define PIC_OFS_OFFSET_B  12'h00c
`define PIC_OFS_PGAIN     12'h010
`define PIC_OFS_ITIME     12'h014
`define PIC_OFS_MANUAL    12'h018
`define PIC_OFS_LIM_LO    12'h01c
`define PIC_OFS_LIM_HI    12'h020
`define PIC_OFS_STATUS    12'h024
`define PIC_OFS_SCALED    12'h028

`define PIC_CTRL_DIR_BIT  0
`define PIC_STAT_AUTO_BIT 16
`define PIC_STAT_RST_BIT  17

`define PIC_RST_DIR       1'b1
`define PIC_RST_SETPOINT  16'sh0000
`define PIC_RST_GAIN_A    16'sh0064
`define PIC_RST_OFFSET_B  16'sh0000
`define PIC_RST_PGAIN     16'h0064
`define PIC_RST_ITIME     16'h003c
`define PIC_RST_MANUAL    16'h0000
`define PIC_RST_LIM_LO    16'shd8f0
`define PIC_RST_LIM_HI    16'sh4e20

`define PIC_ITIME_OFF     16'h176f
`define PIC_OUT_MAX       16'sh03e8
`define PIC_GAIN_SCALE    100
`define PIC_SAMPLE_MS     500
`define PIC_CLK_KHZ       200000

`endif

// [pic_pkg.sv]
// types shared by the pi controller
`default_nettype none
package pic_pkg;
  typedef struct packed {
    logic               dir_up;
    logic signed [15:0] setpoint;
    logic signed [15:0] gain_a;
    logic signed [15:0] offset_b;
    logic        [15:0] proportional_gain;
    logic        [15:0] integral_time;
    logic        [15:0] manual_output_value;
    logic signed [15:0] lim_lo;
    logic signed [15:0] lim_hi;
  } pic_cfg_t;

  typedef enum logic [2:0] {
    ST_MAN  = 3'b001,
    ST_AUTO = 3'b010,
    ST_RST  = 3'b100
  } pic_state_t;
endpackage
`default_nettype wire

// [pic_ctrl.sv]
// pi process controller with apb parameter registers
//
// Our own choices: the address map and the APB slave port.
`include "pic_defs.svh"
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int unsigned TICK_CYC = `PIC_SAMPLE_MS * `PIC_CLK_KHZ
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               mode_auto,
  input  wire logic               ctl_reset,
  input  wire logic signed [15:0] process_input,
  output logic      [9:0]         manipulated_output
);

  localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  generate
    if (TICK_CYC < 2) begin : g_bad_tick
      $error("TICK_CYC must be at least 2");
    end
  endgenerate

  // ---------------- apb slave ----------------
  pic_cfg_t         cfg_r, cfg_nxt;
  logic [31:0]      rdat_r, rdat_nxt;
  logic             err_r, err_nxt;
  logic             setup;
  logic             wr_acc;
  logic             hit;
  logic signed [15:0] acc_r, acc_nxt;
  logic signed [15:0] scaled;
  pic_state_t       state_r, state_nxt;

  assign setup  = psel & ~penable;
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign prdata = rdat_r;
  assign pslverr = err_r & psel & penable;

  always_comb begin
    hit = 1'b1;
    rdat_nxt = rdat_r;
    case (paddr)
      `PIC_OFS_CTRL:     rdat_nxt = {31'h0, cfg_r.dir_up};
      `PIC_OFS_SETPOINT: rdat_nxt = {{16{cfg_r.setpoint[15]}}, cfg_r.setpoint};
      `PIC_OFS_GAIN_A:   rdat_nxt = {{16{cfg_r.gain_a[15]}}, cfg_r.gain_a};
      `PIC_OFS_OFFSET_B: rdat_nxt = {{16{cfg_r.offset_b[15]}}, cfg_r.offset_b};
      `PIC_OFS_PGAIN:    rdat_nxt = {16'h0, cfg_r.proportional_gain};
      `PIC_OFS_ITIME:    rdat_nxt = {16'h0, cfg_r.integral_time};
      `PIC_OFS_MANUAL:   rdat_nxt = {16'h0, cfg_r.manual_output_value};
      `PIC_OFS_LIM_LO:   rdat_nxt = {{16{cfg_r.lim_lo[15]}}, cfg_r.lim_lo};
      `PIC_OFS_LIM_HI:   rdat_nxt = {{16{cfg_r.lim_hi[15]}}, cfg_r.lim_hi};
      `PIC_OFS_STATUS:   rdat_nxt = {14'h0, state_r == ST_RST, state_r == ST_AUTO,
                                     acc_r};
      `PIC_OFS_SCALED:   rdat_nxt = {{16{scaled[15]}}, scaled};
      default: begin
        hit = 1'b0;
        rdat_nxt = 32'h0;
      end
    endcase
    if (!setup) begin
      rdat_nxt = rdat_r;
    end
    err_nxt = setup ? ~hit : err_r;
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_acc) begin
      case (paddr)
        `PIC_OFS_CTRL:     cfg_nxt.dir_up = pwdata[`PIC_CTRL_DIR_BIT];
        `PIC_OFS_SETPOINT: cfg_nxt.setpoint = pwdata[15:0];
        `PIC_OFS_GAIN_A:   cfg_nxt.gain_a = pwdata[15:0];
        `PIC_OFS_OFFSET_B: cfg_nxt.offset_b = pwdata[15:0];
        `PIC_OFS_PGAIN:    cfg_nxt.proportional_gain = pwdata[15:0];
        `PIC_OFS_ITIME:    cfg_nxt.integral_time = pwdata[15:0];
        `PIC_OFS_MANUAL:   cfg_nxt.manual_output_value = pwdata[15:0];
        `PIC_OFS_LIM_LO:   cfg_nxt.lim_lo = pwdata[15:0];
        `PIC_OFS_LIM_HI:   cfg_nxt.lim_hi = pwdata[15:0];
        default:           cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r.dir_up              <= `PIC_RST_DIR;
      cfg_r.setpoint            <= `PIC_RST_SETPOINT;
      cfg_r.gain_a              <= `PIC_RST_GAIN_A;
      cfg_r.offset_b            <= `PIC_RST_OFFSET_B;
      cfg_r.proportional_gain   <= `PIC_RST_PGAIN;
      cfg_r.integral_time       <= `PIC_RST_ITIME;
      cfg_r.manual_output_value <= `PIC_RST_MANUAL;
      cfg_r.lim_lo              <= `PIC_RST_LIM_LO;
      cfg_r.lim_hi              <= `PIC_RST_LIM_HI;
      rdat_r                    <= 32'h0;
      err_r                     <= 1'b0;
    end else begin
      cfg_r  <= cfg_nxt;
      rdat_r <= rdat_nxt;
      err_r  <= err_nxt;
    end
  end

  // ---------------- sampling tick ----------------
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          tick;

  assign tick = (cnt_r == CW'(TICK_CYC - 1));                     // [RQ13]

  always_comb begin
    cnt_nxt = tick ? '0 : cnt_r + CW'(1);                         // [RQ18]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------- scaling and clamp ----------------
  logic signed [47:0] prod;
  logic signed [47:0] lin;

  always_comb begin
    prod = 48'(process_input) * 48'(cfg_r.gain_a);
    lin  = prod / 48'sd100 + 48'(cfg_r.offset_b);                  // [RQ4]
    if (process_input > cfg_r.lim_hi) begin
      scaled = cfg_r.lim_hi;                                      // [RQ9]
    end else if (process_input < cfg_r.lim_lo) begin
      scaled = cfg_r.lim_lo;                                      // [RQ10]
    end else begin
      scaled = lin[15:0];
    end
  end

  // ---------------- control law ----------------
  // the output itself is the integral sum, so each step moves it the way of
  // the error and never reverses while the error keeps its sign
  logic signed [47:0] err;
  logic signed [47:0] p_step;
  logic signed [47:0] i_step;
  logic signed [47:0] step;
  logic signed [47:0] sum;
  logic        [15:0] pg_eff;
  logic        [15:0] it_eff;
  logic signed [47:0] gain_s;
  logic signed [47:0] time_s;
  logic               p_on;
  logic               i_on;

  always_comb begin
    err = cfg_r.dir_up ? 48'(cfg_r.setpoint) - 48'(scaled)         // [RQ6]
                       : 48'(scaled) - 48'(cfg_r.setpoint);        // [RQ7]
    p_on   = (cfg_r.proportional_gain != 16'h0);                  // [RQ14]
    i_on   = (cfg_r.integral_time != `PIC_ITIME_OFF);              // [RQ15]
    pg_eff = p_on ? cfg_r.proportional_gain : 16'(`PIC_GAIN_SCALE);
    it_eff = (cfg_r.integral_time == 16'h0) ? 16'h1 : cfg_r.integral_time;
    // unsigned factors would turn the whole product unsigned and wreck a
    // negative error, so they are widened first and then marked signed
    gain_s = $signed(48'(pg_eff));
    time_s = $signed(48'(it_eff));
    p_step = p_on ? (err * gain_s) / 48'sd100 : 48'sd0;
    i_step = i_on ? (err * gain_s) / (48'sd200 * time_s) : 48'sd0;
    step   = p_step + i_step;                                     // [RQ8]
    // truncation must not stall the loop on a small error
    if (step == 48'sd0 && err != 48'sd0 && (p_on || i_on)) begin
      step = (err > 48'sd0) ? 48'sd1 : -48'sd1;                   // [RQ8]
    end
    sum = 48'(acc_r) + step;
    if (err == 48'sd0) begin
      sum = 48'(acc_r);                                           // [RQ5]
    end
  end

  // ---------------- mode and output ----------------
  always_comb begin
    state_nxt = state_r;
    acc_nxt   = acc_r;
    case (state_r)
      ST_MAN: begin
        if (tick) begin
          acc_nxt = 16'(cfg_r.manual_output_value);                // [RQ1]
        end
        if (mode_auto) begin
          state_nxt = ST_AUTO;                                    // [RQ2]
          acc_nxt   = 16'(cfg_r.manual_output_value);              // [RQ3]
        end
      end
      ST_AUTO: begin
        if (!mode_auto) begin
          state_nxt = ST_MAN;
        end else if (tick) begin
          if (sum > 48'(`PIC_OUT_MAX)) begin
            acc_nxt = `PIC_OUT_MAX;                                // [RQ16]
          end else if (sum < 48'sd0) begin
            acc_nxt = 16'sh0;                                      // [RQ16]
          end else begin
            acc_nxt = sum[15:0];                                   // [RQ2]
          end
        end
      end
      ST_RST: begin
        state_nxt = ST_MAN;
      end
      default: begin
        state_nxt = ST_MAN;
        acc_nxt   = 16'sh0;
      end
    endcase
    // reset wins over every mode and waits for no tick
    if (ctl_reset) begin
      state_nxt = ST_RST;                                         // [RQ12]
      acc_nxt   = 16'sh0;                                          // [RQ11] [RQ17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_MAN;
      acc_r   <= 16'sh0;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
    end
  end

  assign manipulated_output = acc_r[9:0];

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter_auto;
    state_r == ST_MAN && mode_auto && !ctl_reset;
  endsequence

  sequence s_auto_tick;
    state_r == ST_AUTO && mode_auto && !ctl_reset && tick;
  endsequence

  a_manual_value: assert property (                                // [RQ1]
    state_r == ST_MAN && !mode_auto && !ctl_reset && tick
    |=> acc_r == $signed($past(cfg_r.manual_output_value)))
    else $error("manual mode output differs from manual value");

  a_auto_seed: assert property (                                   // [RQ3]
    s_enter_auto |=> state_r == ST_AUTO
      && acc_r == $signed($past(cfg_r.manual_output_value)))
    else $error("auto entry did not seed the integral sum");

  a_equal_hold: assert property (                                  // [RQ5]
    s_auto_tick and (scaled == cfg_r.setpoint) |=> $stable(acc_r))
    else $error("output changed at setpoint");

  a_up_above: assert property (                                    // [RQ6]
    s_auto_tick and (cfg_r.dir_up && scaled > cfg_r.setpoint)
    |=> acc_r <= $past(acc_r))
    else $error("upward action raised output above setpoint");

  a_down_above: assert property (                                  // [RQ7]
    s_auto_tick and (!cfg_r.dir_up && scaled > cfg_r.setpoint)
    |=> acc_r >= $past(acc_r))
    else $error("downward action lowered output above setpoint");

  a_clamp_high: assert property (                                  // [RQ9]
    process_input > cfg_r.lim_hi |-> scaled == cfg_r.lim_hi)
    else $error("scaled value not held at max");

  a_clamp_low: assert property (                                   // [RQ10]
    process_input < cfg_r.lim_lo && process_input <= cfg_r.lim_hi
    |-> scaled == cfg_r.lim_lo)
    else $error("scaled value not held at min");

  a_reset_zero: assert property (                                  // [RQ17]
    ctl_reset |=> acc_r == 16'sh0 && state_r == ST_RST)
    else $error("reset input did not zero the output");

  a_reset_mode: assert property (                                  // [RQ12]
    ctl_reset ##1 ctl_reset |-> state_r == ST_RST && acc_r == 16'sh0)
    else $error("mode select acted during reset");

  a_out_range: assert property (                                   // [RQ16]
    acc_r >= 16'sh0 && acc_r <= `PIC_OUT_MAX)
    else $error("output outside 0 to 1000");

  a_tick_spacing: assert property (                                // [RQ13]
    tick |=> !tick && cnt_r == CW'(0))
    else $error("tick spacing broken");

  a_hold_between: assert property (                                // [RQ18]
    !tick && !ctl_reset && !(state_r == ST_MAN && mode_auto) |=> $stable(acc_r))
    else $error("output changed between ticks");

endmodule
`default_nettype wire

// [pic_plant.sv]
// plant model: sensor that feeds the commanded process value to the controller
`default_nettype none
module pic_plant
  import pic_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [15:0] proc_cmd,
  input  wire logic [9:0]         manipulated_output,
  output logic signed [15:0]      process_input,
  output logic                    act_over
);
  timeunit 1ns;
  timeprecision 1ps;
  // actuator load not modelled: the bench steers the process value directly;
  // the actuator only latches a command beyond full scale for the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_input <= 16'sh0000;
      act_over      <= 1'b0;
    end else begin
      process_input <= proc_cmd;
      act_over      <= act_over | (manipulated_output > 10'd1000);
    end
  end
endmodule
`default_nettype wire

// [pic_tb.sv]
// self-checking bench for the pi controller
`default_nettype none
module tb
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 16;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [15:0] inp;
  } pic_row_t;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               mode_auto;
  logic               ctl_reset;
  logic signed [15:0] process_input;
  logic signed [15:0] proc_cmd;
  logic               act_over;
  logic [9:0]         manipulated_output;
  logic [31:0]        rd;
  logic               se;
  int                 n;
  int                 err_total;
  int                 samples_checked;
  // reset values first, then scaling with gain 2.00 and offset 5
  localparam pic_row_t rows [19] = '{
    '{1'b0, 12'h000, 32'h0000_0001, 16'h0000}, '{1'b0, 12'h004, 32'h0, 16'h0000},
    '{1'b0, 12'h008, 32'h0000_0064, 16'h0000}, '{1'b0, 12'h00c, 32'h0, 16'h0000},
    '{1'b0, 12'h010, 32'h0000_0064, 16'h0000}, '{1'b0, 12'h014, 32'h3c, 16'h0000},
    '{1'b0, 12'h018, 32'h0, 16'h0000}, '{1'b0, 12'h01c, 32'hffff_d8f0, 16'h0000},
    '{1'b0, 12'h020, 32'h0000_4e20, 16'h0000}, '{1'b0, 12'h02c, 32'h0, 16'h0000},
    '{1'b1, 12'h02c, 32'h0000_1234, 16'h0000}, '{1'b0, 12'h02c, 32'h0, 16'h0000},
    '{1'b1, 12'h008, 32'h0000_00c8, 16'h0000}, '{1'b1, 12'h00c, 32'h5, 16'h0000},
    '{1'b0, 12'h028, 32'h0000_00cd, 16'h0064}, '{1'b0, 12'h028, 32'h4e20, 16'h7530},
    '{1'b0, 12'h028, 32'hffff_d8f0, 16'hb1e0}, '{1'b1, 12'h024, 32'hffff, 16'h0064},
    '{1'b0, 12'h024, 32'h0, 16'h0064}
  };

  pic_ctrl #(.TICK_CYC(TICK)) u_pic_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_auto(mode_auto), .ctl_reset(ctl_reset), .process_input(process_input),
    .manipulated_output(manipulated_output)
  );
  pic_plant u_pic_plant (
    .pclk(pclk), .presetn(presetn), .proc_cmd(proc_cmd),
    .manipulated_output(manipulated_output), .process_input(process_input),
    .act_over(act_over)
  );

  always #2.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk("wait states", k, 1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // sampled on falling edges so output updates have settled; c counts cycles waited
  task automatic wait_val(input logic [9:0] e, input int lim, output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (manipulated_output !== e && c < lim);
    chk("manipulated_output", {22'h0, manipulated_output}, {22'h0, e});
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode_auto = 1'b0;
    ctl_reset = 1'b0;
    proc_cmd = 16'sh0000;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    chk("reset output", {22'h0, manipulated_output}, 32'h0);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      proc_cmd <= rows[i].inp;
      repeat (4) @(posedge pclk);
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, se);
      if (!rows[i].wr) chk("prdata", rd, rows[i].d);
      chk("pslverr", {31'h0, se}, {31'h0, rows[i].a == 12'h02c});
    end
    apb(1'b1, 12'h018, 32'h12c, rd, se);
    apb(1'b1, 12'h004, 32'hcd, rd, se);
    wait_val(10'd300, 40, n);
    apb(1'b1, 12'h018, 32'h1f4, rd, se);
    mode_auto <= 1'b1;
    wait_val(10'd500, 3, n);
    repeat (40) @(negedge pclk);
    chk("held output", {22'h0, manipulated_output}, 32'd500);
    apb(1'b0, 12'h024, 32'h0, rd, se);
    chk("status in auto", rd, 32'h0001_01f4);
    apb(1'b1, 12'h004, 32'h0, rd, se);
    wait_val(10'd294, 40, n);
    wait_val(10'd88, 40, n);
    wait_val(10'd0, 40, n);
    apb(1'b1, 12'h000, 32'h0, rd, se);
    wait_val(10'd206, 40, n);
    wait_val(10'd412, 40, n);
    chk("tick spacing", n, TICK);
    wait_val(10'd1000, 80, n);
    apb(1'b1, 12'h014, 32'h176f, rd, se);
    apb(1'b1, 12'h000, 32'h1, rd, se);
    wait_val(10'd795, 40, n);
    apb(1'b1, 12'h010, 32'h0, rd, se);
    apb(1'b1, 12'h014, 32'h3c, rd, se);
    wait_val(10'd794, 40, n);
    @(posedge pclk);
    ctl_reset <= 1'b1;
    wait_val(10'd0, 3, n);
    repeat (40) @(negedge pclk);
    chk("output in reset", {22'h0, manipulated_output}, 32'h0);
    apb(1'b0, 12'h024, 32'h0, rd, se);
    chk("status", rd, 32'h0002_0000);
    ctl_reset <= 1'b0;
    wait_val(10'd500, 6, n);
    chk("actuator range", {31'h0, act_over}, 32'h0);
    conclude();
  end

  // whole run is under a thousand cycles; this 10000-cycle bound leaves a wide margin
  initial begin
    #50000;
    err_total++;
    $display("Error watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
